// ### design/pio_pkg.sv
// Package: register map, pin vector layout and reset values for the phone I/O ports
package pio_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [3:0] PIO_ADDR_PA_DATA = 4'h0;
  localparam logic [3:0] PIO_ADDR_PA_DIR  = 4'h1;
  localparam logic [3:0] PIO_ADDR_PB_DATA = 4'h2;
  localparam logic [3:0] PIO_ADDR_PB_DIR  = 4'h3;
  localparam logic [3:0] PIO_ADDR_PC_DATA = 4'h4;
  localparam logic [3:0] PIO_ADDR_PC_DIR  = 4'h5;
  localparam logic [3:0] PIO_ADDR_PD_DATA = 4'h6;
  localparam logic [3:0] PIO_ADDR_PD_DIR  = 4'h7;
  localparam logic [3:0] PIO_ADDR_CTRL    = 4'h8;
  localparam logic [3:0] PIO_ADDR_PA_PIN  = 4'h9;
  localparam logic [3:0] PIO_ADDR_PB_PIN  = 4'hA;
  localparam logic [3:0] PIO_ADDR_PC_PIN  = 4'hB;
  localparam logic [3:0] PIO_ADDR_PD_PIN  = 4'hC;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int PIO_CTRL_MFI_EN  = 0;
  localparam int PIO_CTRL_EXT_EN  = 1;
  localparam int PIO_CTRL_TMR_RISE = 2;
  localparam int PIO_CTRL_W       = 3;

  // ****************************************
  // Synchronised pin vector layout
  // ****************************************
  localparam int PIO_PIN_W   = 19;
  localparam int PIO_POS_PA  = 0;
  localparam int PIO_POS_PB  = 8;
  localparam int PIO_POS_PC0 = 12;
  localparam int PIO_POS_PC1 = 13;
  localparam int PIO_POS_PD  = 14;
  localparam int PIO_POS_TMR = 18;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PIO_RST_DIR8  = 8'h00;
  localparam logic [7:0] PIO_RST_DAT8  = 8'h00;
  localparam logic [3:0] PIO_RST_DIR4  = 4'h0;
  localparam logic [3:0] PIO_RST_DAT4  = 4'h0;
  localparam logic [3:0] PIO_RST_PCDAT = 4'hC;
  localparam logic [1:0] PIO_RST_PCDIR = 2'h0;
  localparam logic [2:0] PIO_RST_CTRL  = 3'h0;

endpackage

// ### design/pio_ports.sv
// Top module: phone MCU general-purpose I/O ports with edge, wake and timer-input logic
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module pio_ports
  import pio_pkg::*;
(
  input  wire logic       REF_CLK_IN,          // 40 MHz system clock
  input  wire logic       RESET_N_IN,          // Synchronous reset, active low
  input  wire logic [3:0] ADDR_IN,             // Register address
  input  wire logic [7:0] WDATA_IN,            // Write data
  input  wire logic       WR_IN,               // Write strobe
  input  wire logic       RD_IN,               // Read strobe
  output logic      [7:0] RDATA_OUT,           // Read data, cycle after strobe
  input  wire logic [7:0] CFG_PA_WAKE_IN,      // Wake-enable options
  input  wire logic [7:0] CFG_PA_PULLUP_IN,    // Wake port pull-up options
  input  wire logic [3:0] CFG_PB_PULLUP_IN,    // Nibble B pull-up options
  input  wire logic [1:0] CFG_PC_PULLUP_IN,    // Single pins pull-up options
  input  wire logic       CFG_PD_PULLUP_IN,    // Whole-nibble pull-up option
  input  wire logic       IDLE_MODE_IN,        // Device in idle mode
  input  wire logic       POWERDOWN_IN,        // Device in power-down
  input  wire logic [7:0] PA_IN,               // Wake port pin levels
  output logic      [7:0] PA_OUT,              // Wake port drive levels
  output logic      [7:0] PA_OE_OUT,           // Wake port drive enables
  output logic      [7:0] PA_PULLUP_OUT,       // Wake port pull-up enables
  input  wire logic [3:0] PB_IN,               // Nibble B pin levels
  output logic      [3:0] PB_OUT,              // Nibble B drive levels
  output logic      [3:0] PB_OE_OUT,           // Nibble B drive enables
  output logic      [3:0] PB_PULLUP_OUT,       // Nibble B pull-up enables
  input  wire logic [1:0] PC_IN,               // Edge pin [0], single pin [1]
  output logic      [1:0] PC_OUT,              // Drive levels of those two
  output logic      [1:0] PC_OE_OUT,           // Drive enables of those two
  output logic      [1:0] PC_PULLUP_OUT,       // Pull-up enables of those two
  output logic      [1:0] OD_OUT,              // Open-drain outputs, level when driven
  output logic      [1:0] OD_OE_OUT,           // Open-drain pull-low enables
  input  wire logic [3:0] PD_IN,               // Pull-up nibble pin levels
  output logic      [3:0] PD_OUT,              // Pull-up nibble drive levels
  output logic      [3:0] PD_OE_OUT,           // Pull-up nibble drive enables
  output logic      [3:0] PD_PULLUP_OUT,       // Pull-up nibble pull-up enables
  input  wire logic       TMR_INT_IN,          // Shared interrupt/timer input
  output logic            EDGE_IRQ_OUT,        // Edge pin interrupt request pulse
  output logic            EXT_INT_OUT,         // External interrupt request pulse
  output logic            TIMER_ZERO_CLOCK_INPUT_TICK_OUT,       // Timer zero count pulse
  output logic            WAKE_OUT             // Wake-up request pulse
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [PIO_PIN_W-1:0] sync1;
    logic [PIO_PIN_W-1:0] sync2;
    logic [PIO_PIN_W-1:0] prev;
    logic [7:0]           pa_dat;
    logic [7:0]           pa_dir;
    logic [3:0]           pb_dat;
    logic [3:0]           pb_dir;
    logic [3:0]           pc_dat;
    logic [1:0]           pc_dir;
    logic [3:0]           pd_dat;
    logic [3:0]           pd_dir;
    logic [PIO_CTRL_W-1:0] ctrl;
    logic [7:0]           rdata;
    logic                 edge_irq;
    logic                 ext_int;
    logic                 tmr_tick;
    logic                 wake;
  } pio_state_s;

  pio_state_s           q;
  pio_state_s           d;
  logic [PIO_PIN_W-1:0] pins_w;
  logic [PIO_PIN_W-1:0] fall_w;
  logic [PIO_PIN_W-1:0] rise_w;
  logic                 pc0_irq_w;
  logic                 pa_wake_w;

  // Shared input is sampled plain, it has no pull-up output
  assign pins_w = {TMR_INT_IN, PD_IN, PC_IN, PB_IN, PA_IN};

  // Edges from second stage against its delayed copy
  assign fall_w = q.prev & ~q.sync2;
  assign rise_w = ~q.prev & q.sync2;

  // Falling edge on the edge pin while enabled
  assign pc0_irq_w = q.ctrl[PIO_CTRL_MFI_EN] & fall_w[PIO_POS_PC0];

  // Falling edge on any wake-enabled pin
  assign pa_wake_w = |(CFG_PA_WAKE_IN & fall_w[PIO_POS_PA +: 8]);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.sync1 = pins_w;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;

    d.edge_irq = pc0_irq_w;
    // Idle-mode wake by edge pin, power-down wake by wake port
    d.wake     = (IDLE_MODE_IN & pc0_irq_w) | (POWERDOWN_IN & pa_wake_w);
    d.ext_int  = q.ctrl[PIO_CTRL_EXT_EN] & fall_w[PIO_POS_TMR];
    // Selected count edge for timer zero
    d.tmr_tick = q.ctrl[PIO_CTRL_TMR_RISE] ? rise_w[PIO_POS_TMR] : fall_w[PIO_POS_TMR];

    if (WR_IN) begin
      unique case (ADDR_IN)
        PIO_ADDR_PA_DATA: d.pa_dat = WDATA_IN;
        PIO_ADDR_PA_DIR:  d.pa_dir = WDATA_IN;
        PIO_ADDR_PB_DATA: d.pb_dat = WDATA_IN[3:0];
        PIO_ADDR_PB_DIR:  d.pb_dir = WDATA_IN[3:0];
        PIO_ADDR_PC_DATA: d.pc_dat = WDATA_IN[3:0];
        PIO_ADDR_PC_DIR:  d.pc_dir = WDATA_IN[1:0];
        PIO_ADDR_PD_DATA: d.pd_dat = WDATA_IN[3:0];
        PIO_ADDR_PD_DIR:  d.pd_dir = WDATA_IN[3:0];
        PIO_ADDR_CTRL:    d.ctrl   = WDATA_IN[PIO_CTRL_W-1:0];
        default: ;
      endcase
    end

    // Read data stand one cycle only
    d.rdata = 8'h00;
    if (RD_IN) begin
      unique case (ADDR_IN)
        PIO_ADDR_PA_DATA: d.rdata = q.pa_dat;
        PIO_ADDR_PA_DIR:  d.rdata = q.pa_dir;
        PIO_ADDR_PB_DATA: d.rdata = {4'h0, q.pb_dat};
        PIO_ADDR_PB_DIR:  d.rdata = {4'h0, q.pb_dir};
        PIO_ADDR_PC_DATA: d.rdata = {4'h0, q.pc_dat};
        PIO_ADDR_PC_DIR:  d.rdata = {6'h00, q.pc_dir};
        PIO_ADDR_PD_DATA: d.rdata = {4'h0, q.pd_dat};
        PIO_ADDR_PD_DIR:  d.rdata = {4'h0, q.pd_dir};
        PIO_ADDR_CTRL:    d.rdata = {5'h00, q.ctrl};
        PIO_ADDR_PA_PIN:  d.rdata = q.sync2[PIO_POS_PA +: 8];
        PIO_ADDR_PB_PIN:  d.rdata = {4'h0, q.sync2[PIO_POS_PB +: 4]};
        PIO_ADDR_PC_PIN:  d.rdata = {3'h0, q.sync2[PIO_POS_TMR], 2'h0, q.sync2[PIO_POS_PC1], q.sync2[PIO_POS_PC0]};
        PIO_ADDR_PD_PIN:  d.rdata = {4'h0, q.sync2[PIO_POS_PD +: 4]};
        default:          d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      q          <= '0;
      q.pa_dat   <= PIO_RST_DAT8;
      q.pa_dir   <= PIO_RST_DIR8;
      q.pb_dat   <= PIO_RST_DAT4;
      q.pb_dir   <= PIO_RST_DIR4;
      q.pc_dat   <= PIO_RST_PCDAT;
      q.pc_dir   <= PIO_RST_PCDIR;
      q.pd_dat   <= PIO_RST_DAT4;
      q.pd_dir   <= PIO_RST_DIR4;
      q.ctrl     <= PIO_RST_CTRL;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Pin drive and pull-ups
  // ****************************************
  // Direction bit set drives the pin
  assign PA_OUT    = q.pa_dat;
  assign PA_OE_OUT = q.pa_dir;
  assign PB_OUT    = q.pb_dat;
  assign PB_OE_OUT = q.pb_dir;
  assign PC_OUT    = q.pc_dat[1:0];
  assign PC_OE_OUT = q.pc_dir;
  assign PD_OUT    = q.pd_dat;
  assign PD_OE_OUT = q.pd_dir;
  // Open drain: latch zero pulls low
  assign OD_OUT    = 2'h0;
  assign OD_OE_OUT = ~q.pc_dat[3:2];

  assign PA_PULLUP_OUT = CFG_PA_PULLUP_IN & ~q.pa_dir;
  assign PB_PULLUP_OUT = CFG_PB_PULLUP_IN & ~q.pb_dir;
  assign PC_PULLUP_OUT = CFG_PC_PULLUP_IN & ~q.pc_dir;
  // One option for the whole nibble
  assign PD_PULLUP_OUT = {4{CFG_PD_PULLUP_IN}} & ~q.pd_dir;

  assign RDATA_OUT     = q.rdata;
  assign EDGE_IRQ_OUT  = q.edge_irq;
  assign EXT_INT_OUT   = q.ext_int;
  assign TIMER_ZERO_CLOCK_INPUT_TICK_OUT = q.tmr_tick;
  assign WAKE_OUT      = q.wake;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  AST_PC0_IRQ: assert property (q.ctrl[PIO_CTRL_MFI_EN] && $fell(q.sync2[PIO_POS_PC0]) |-> ##1 EDGE_IRQ_OUT)
    else $error("edge pin fall gave no request");
  AST_IRQ_SINGLE: assert property (EDGE_IRQ_OUT |=> !EDGE_IRQ_OUT)
    else $error("edge request longer than one cycle");
  AST_IDLE_WAKE: assert property (EDGE_IRQ_OUT && $past(IDLE_MODE_IN) |-> WAKE_OUT)
    else $error("idle wake missing");
  AST_PA_WAKE: assert property (POWERDOWN_IN && pa_wake_w |=> WAKE_OUT)
    else $error("wake port wake missing");
  AST_WAKE_CAUSE: assert property (WAKE_OUT |-> $past(IDLE_MODE_IN || POWERDOWN_IN))
    else $error("wake without low-power mode");
  AST_DIR_WRITE: assert property (WR_IN && ADDR_IN == PIO_ADDR_PA_DIR |=> PA_OE_OUT == $past(WDATA_IN))
    else $error("direction write not applied");
  AST_PULLUP: assert property ((PA_PULLUP_OUT & PA_OE_OUT) == 8'h00)
    else $error("pull-up on driven pin");
  AST_PD_NIBBLE: assert property (PD_OE_OUT == 4'h0 |-> PD_PULLUP_OUT == {4{CFG_PD_PULLUP_IN}})
    else $error("nibble pull-up not uniform");
  AST_EXT_FALL: assert property (EXT_INT_OUT |-> $past(q.prev[PIO_POS_TMR] && !q.sync2[PIO_POS_TMR]))
    else $error("external interrupt not on falling edge");
  AST_TMR_EDGE: assert property (TIMER_ZERO_CLOCK_INPUT_TICK_OUT |-> $past(q.sync2[PIO_POS_TMR] == q.ctrl[PIO_CTRL_TMR_RISE]))
    else $error("timer counted wrong edge");
  AST_RESET: assert property (disable iff (1'b0) !RESET_N_IN |=> PA_OE_OUT == 8'h00 && !WAKE_OUT)
    else $error("reset not applied");

  COV_IDLE_WAKE: cover property (EDGE_IRQ_OUT && WAKE_OUT);
  COV_PA_WAKE:   cover property (POWERDOWN_IN && WAKE_OUT);
  COV_TMR_RISE:  cover property (TIMER_ZERO_CLOCK_INPUT_TICK_OUT && q.ctrl[PIO_CTRL_TMR_RISE]);

endmodule

// ### testbench/pio_pin_model.sv
// Board-side pin model: external drivers, pull-ups and floating pins
`timescale 1ns/10ps
module pio_pin_model #(
  parameter int W = 8                   // Pin count
) (
  input  wire logic         clk_in,     // System clock
  input  wire logic [W-1:0] oe_in,      // Device drive enables
  input  wire logic [W-1:0] drv_in,     // Device drive levels
  input  wire logic [W-1:0] pu_in,      // Device pull-up enables
  input  wire logic [W-1:0] ext_en_in,  // Board driver enables
  input  wire logic [W-1:0] ext_in,     // Board driver levels
  output logic      [W-1:0] lvl_out     // Resolved pin levels
);
  logic [W-1:0] flt_q = '0;
  // Floating pins toggle so no stale level survives
  always_ff @(posedge clk_in) flt_q <= ~flt_q;
  always_comb lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
                      | (~oe_in & ~ext_en_in & (pu_in | flt_q));
endmodule

// ### testbench/pio_ports_bench.sv
// Self-checking bench for the phone I/O ports
`timescale 1ns/10ps
module pio_ports_bench
  import pio_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, idle = 1'b0, pwd = 1'b0;
  logic        tmr = 1'b1, cfg_pd = 1'b0, irq, ext, tick, wake;
  logic [3:0]  addr = 4'h0, cfg_pb = 4'h0, pb_en = 4'hF, pb_i, pb_o, pb_oe, pb_pu, pd_i, pd_o, pd_oe, pd_pu;
  logic [7:0]  wd = 8'h00, cfg_wake = 8'h00, cfg_pa = 8'h00, pa_x = 8'hFF, pa_i, pa_o, pa_oe, pa_pu, rdata;
  logic [1:0]  cfg_pc = 2'h0, pc_x = 2'h3, pc_i, pc_o, pc_oe, pc_pu, pc_en = 2'h3, od_o, od_oe;
  logic [3:0]  pd_en = 4'hF, pd_x = 4'hF;
  logic [7:0]  pa_en = 8'hFF;
  logic [31:0] seed = 32'hA6754294;
  logic [7:0]  r0, r1, r2;
  int          failures = 0, check_count = 0, cyc = 0, c[4];
  // Fields: ctrl[15:13] idle[12] powerdown[11] pin[10:9] level[8] {wake,tick,ext,edge}[3:0]
  logic [15:0] tab [12] = '{16'h2001, 16'h2100, 16'h3009, 16'h3100, 16'h0000, 16'h0100,
                            16'h4206, 16'h4300, 16'h8200, 16'h8304, 16'h0C08, 16'h0E00};

  pio_ports DUT (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr_s), .RD_IN(rd_s),
    .RDATA_OUT(rdata), .CFG_PA_WAKE_IN(cfg_wake), .CFG_PA_PULLUP_IN(cfg_pa), .CFG_PB_PULLUP_IN(cfg_pb),
    .CFG_PC_PULLUP_IN(cfg_pc), .CFG_PD_PULLUP_IN(cfg_pd), .IDLE_MODE_IN(idle), .POWERDOWN_IN(pwd),
    .PA_IN(pa_i), .PA_OUT(pa_o), .PA_OE_OUT(pa_oe), .PA_PULLUP_OUT(pa_pu),
    .PB_IN(pb_i), .PB_OUT(pb_o), .PB_OE_OUT(pb_oe), .PB_PULLUP_OUT(pb_pu),
    .PC_IN(pc_i), .PC_OUT(pc_o), .PC_OE_OUT(pc_oe), .PC_PULLUP_OUT(pc_pu), .OD_OUT(od_o), .OD_OE_OUT(od_oe),
    .PD_IN(pd_i), .PD_OUT(pd_o), .PD_OE_OUT(pd_oe), .PD_PULLUP_OUT(pd_pu), .TMR_INT_IN(tmr),
    .EDGE_IRQ_OUT(irq), .EXT_INT_OUT(ext), .TIMER_ZERO_CLOCK_INPUT_TICK_OUT(tick), .WAKE_OUT(wake));
  pio_pin_model #(.W(8)) u_pa (.clk_in(clk), .oe_in(pa_oe), .drv_in(pa_o), .pu_in(pa_pu),
    .ext_en_in(pa_en), .ext_in(pa_x), .lvl_out(pa_i));
  pio_pin_model #(.W(4)) u_pb (.clk_in(clk), .oe_in(pb_oe), .drv_in(pb_o), .pu_in(pb_pu),
    .ext_en_in(pb_en), .ext_in(4'hF), .lvl_out(pb_i));
  pio_pin_model #(.W(2)) u_pc (.clk_in(clk), .oe_in(pc_oe), .drv_in(pc_o), .pu_in(pc_pu),
    .ext_en_in(pc_en), .ext_in(pc_x), .lvl_out(pc_i));
  pio_pin_model #(.W(4)) u_pd (.clk_in(clk), .oe_in(pd_oe), .drv_in(pd_o), .pu_in(pd_pu),
    .ext_en_in(pd_en), .ext_in(pd_x), .lvl_out(pd_i));

  initial forever #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] pu(input logic [7:0] cfg, input logic [7:0] dir);
    return cfg & ~dir;
  endfunction

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e, m);
  endtask

  // Counts pulses over a fixed window, expects exactly one or none
  task automatic ev(input logic [3:0] e);
    c = '{0, 0, 0, 0};
    repeat (8) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
      chk(8'(c[i]), {7'h00, e[i]}, "event count");
  endtask

  always @(posedge clk) begin
    cyc++;
    c[0] += int'(irq === 1'b1);
    c[1] += int'(ext === 1'b1);
    c[2] += int'(tick === 1'b1);
    c[3] += int'(wake === 1'b1);
    if (cyc == 5000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++)
      rd(4'(a), (a == 4) ? 8'h0C : 8'h00, "reset value");
    rd(4'hD, 8'h00, "unmapped read");
    chk({6'h00, od_oe}, 8'h00, "open drain released");
    $display("Test reset values done");
    repeat (6) begin
      r0 = 8'(rnd());
      r1 = 8'(rnd());
      r2 = 8'(rnd());
      cfg_pa <= r2;
      cfg_pb <= r2[3:0];
      cfg_pd <= r2[4];
      cfg_pc <= r2[6:5];
      wr(PIO_ADDR_PA_DIR, r0);
      wr(PIO_ADDR_PA_DATA, r1);
      wr(PIO_ADDR_PB_DIR, r1);
      wr(PIO_ADDR_PD_DIR, r0);
      wr(PIO_ADDR_PC_DIR, r1);
      chk(pa_oe, r0, "direction");
      chk(pa_o, r1, "drive level");
      chk(pa_pu, pu(r2, r0), "pull-up A");
      chk(8'(pb_pu), pu({4'h0, r2[3:0]}, {4'h0, r1[3:0]}), "pull-up B");
      chk(8'(pc_pu), pu({6'h00, r2[6:5]}, {6'h00, r1[1:0]}), "pull-up C");
      chk(8'(pd_pu), pu({4'h0, {4{r2[4]}}}, {4'h0, r0[3:0]}), "pull-up D");
      rd(PIO_ADDR_PA_DIR, r0, "direction readback");
    end
    $display("Test direction and pull-ups done");
    wr(PIO_ADDR_PA_DIR, 8'h00);
    wr(PIO_ADDR_PB_DIR, 8'h00);
    wr(PIO_ADDR_PC_DIR, 8'h00);
    wr(PIO_ADDR_PD_DIR, 8'h00);
    wr(PIO_ADDR_PC_DATA, 8'h04);
    chk({6'h00, od_oe}, 8'h02, "open drain pull-low");
    chk({6'h00, od_o}, 8'h00, "open drain level");
    pa_x <= 8'(rnd());
    pd_x <= 4'(rnd());
    cfg_pb <= 4'hF;
    pb_en <= 4'h0;
    repeat (5) @(posedge clk);
    rd(PIO_ADDR_PA_PIN, pa_x, "input level");
    rd(PIO_ADDR_PB_PIN, 8'h0F, "pulled-up inputs");
    rd(PIO_ADDR_PD_PIN, {4'h0, pd_x}, "nibble input level");
    rd(PIO_ADDR_PC_PIN, 8'h13, "single pins and shared input");
    pb_en <= 4'hF;
    pa_x <= 8'hFF;
    cfg_wake <= 8'h01;
    ev(4'h0);
    $display("Test pin inputs done");
    foreach (tab[i]) begin
      wr(PIO_ADDR_CTRL, {5'h00, tab[i][15:13]});
      @(posedge clk);
      idle <= tab[i][12];
      pwd <= tab[i][11];
      case (tab[i][10:9])
        2'd0: pc_x[0] <= tab[i][8];
        2'd1: tmr <= tab[i][8];
        default: pa_x[tab[i][9]] <= tab[i][8];
      endcase
      ev(tab[i][3:0]);
    end
    $display("Test pin events done");
    wr(PIO_ADDR_PA_DIR, 8'hFF);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pa_oe, 8'h00, "direction after reset");
    $display("Test mid-run reset done");
    stop_test();
  end
endmodule
